/* design/macrocell_pkg.sv */
// Summary of operation
// - or gate sums up to eight product terms
// - eight independently configured output cells
// - array sees true and inverted inputs
// - clock and enable pins double as inputs
// - empty product term evaluates high
// - true and complement together force low
// - registered cell enabled only by enable pin
// - combinatorial cell enabled by term or always
// - dedicated input cell buffer always off
// - config word: two global, sixteen local bits
// - global bits select registers and emulation
// - polarity bit xors the sum term
// - four muxes steered by global and mode
// - end cells feedback mux uses inverted permit
// - registered device blocks clock/enable as data
// - registered mode is permit0 emul1 mode0
// - flip-flop captures on rising shared clock
// - registered feedback is inverted flip-flop output
// - three combinatorial cell variants supported
// - combinatorial output is permit1 emul0 mode0
// - io modes use seven terms, eighth enables
// - dedicated input is permit1 emul0 mode1
// - flip-flops clear low at power-up
package macrocell_pkg;
  localparam int unsigned NUM_CELLS = 8; // output cells
  localparam int unsigned TERMS_PER_CELL = 8; // product terms per cell
  localparam int unsigned NUM_DED_IN = 12; // dedicated array inputs
  localparam int unsigned SYNC_STAGES = 3; // pin synchroniser depth
  localparam logic FF_RESET = 1'h0; // flip-flop power-up value
  // array input layout: dedicated, clock pin, enable pin, feedbacks
  localparam int unsigned CLK_PIN_POS = NUM_DED_IN;
  localparam int unsigned OE_PIN_POS = NUM_DED_IN + 1;
  localparam int unsigned FB_POS = NUM_DED_IN + 2;
  localparam int unsigned NUM_ARRAY_IN = NUM_DED_IN + 2 + NUM_CELLS;
  // cell modes
  typedef enum logic [4:0] {
    CELL_REG = 5'h01,
    CELL_COMB_OUT = 5'h02,
    CELL_COMB_IO_NR = 5'h04,
    CELL_COMB_IO_R = 5'h08,
    CELL_INPUT = 5'h10
  } cell_mode_e;
endpackage : macrocell_pkg

/* design/programmable_macrocell_array.sv */
`timescale 1ns/100ps
module programmable_macrocell_array #(
  parameter int unsigned NUM_CELLS = macrocell_pkg::NUM_CELLS,
  parameter int unsigned NUM_DED_IN = macrocell_pkg::NUM_DED_IN
) (
  input wire logic core_clk_i, // core clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic [NUM_DED_IN-1:0] data_pin_i, // dedicated input pins
  input wire logic clk_pin_i, // shared clock / array input pin
  input wire logic oe_n_pin_i, // shared enable (low) / array input pin
  input wire logic [NUM_CELLS-1:0] io_pin_i, // level seen on cell pins
  output logic [NUM_CELLS-1:0] io_pin_o, // cell pin drive value
  output logic [NUM_CELLS-1:0] io_pin_oe_o, // cell pin drive enable
  input wire logic register_permit_global_i, // first global bit
  input wire logic emulation_select_global_i, // second global bit
  input wire logic [NUM_CELLS-1:0] cell_mode_local_i, // per cell mode bit
  input wire logic [NUM_CELLS-1:0] cell_polarity_local_i, // per cell polarity
  // array fuses: per cell, per term, true and complement connect
  input wire logic [NUM_CELLS*8*macrocell_pkg::NUM_ARRAY_IN-1:0] fuse_true_i,
  input wire logic [NUM_CELLS*8*macrocell_pkg::NUM_ARRAY_IN-1:0] fuse_comp_i
);
  localparam int unsigned NIN = macrocell_pkg::NUM_ARRAY_IN;
  localparam int unsigned NT = macrocell_pkg::TERMS_PER_CELL;

  // elaboration check: the array layout is fixed by the package
  if (NUM_CELLS != macrocell_pkg::NUM_CELLS ||
      NUM_DED_IN != macrocell_pkg::NUM_DED_IN) begin : g_geom
    $error("array geometry must match the package layout");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change accepted when last two agree
  logic [NUM_DED_IN+2+NUM_CELLS-1:0] sync1_r, sync2_r, sync3_r, pin_r;
  logic [NUM_DED_IN+2+NUM_CELLS-1:0] pin_raw;
  assign pin_raw = {io_pin_i, oe_n_pin_i, clk_pin_i, data_pin_i};
  // idle levels at reset: enable pin reads high, so no registered cell drives before it is seen
  localparam logic [NUM_DED_IN+2+NUM_CELLS-1:0] PIN_IDLE =
    {{NUM_CELLS{1'h0}}, 1'h1, 1'h0, {NUM_DED_IN{1'h0}}};

  // sampling chain
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sync1_r <= PIN_IDLE;
      sync2_r <= PIN_IDLE;
      sync3_r <= PIN_IDLE;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // filtered pin levels
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pin_r <= PIN_IDLE;
    end else begin
      for (int i = 0; i < NUM_DED_IN + 2 + NUM_CELLS; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          pin_r[i] <= sync3_r[i];
        end
      end
    end
  end

  logic clk_lvl, oe_n_lvl;
  logic [NUM_CELLS-1:0] io_lvl;
  assign clk_lvl = pin_r[macrocell_pkg::CLK_PIN_POS];
  assign oe_n_lvl = pin_r[macrocell_pkg::OE_PIN_POS];
  assign io_lvl = pin_r[macrocell_pkg::FB_POS +: NUM_CELLS];

  ////////////////////////////////////////////////////////////////////////////////
  // cell mode decode from the control word
  logic dev_registered; // registers permitted
  assign dev_registered = ~register_permit_global_i;
  macrocell_pkg::cell_mode_e mode [NUM_CELLS];

  always_comb begin
    for (int c = 0; c < NUM_CELLS; c++) begin
      case ({register_permit_global_i, emulation_select_global_i, cell_mode_local_i[c]})
        3'h2: mode[c] = macrocell_pkg::CELL_REG;
        3'h3: mode[c] = macrocell_pkg::CELL_COMB_IO_R;
        3'h4: mode[c] = macrocell_pkg::CELL_COMB_OUT;
        3'h5: mode[c] = macrocell_pkg::CELL_INPUT;
        3'h7: mode[c] = macrocell_pkg::CELL_COMB_IO_NR;
        default: mode[c] = macrocell_pkg::CELL_INPUT; // unlisted: buffer off
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared clock edge detect on filtered clock pin
  logic clk_prev_r;
  logic clk_rise;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      clk_prev_r <= 1'h0;
    end else begin
      clk_prev_r <= clk_lvl;
    end
  end
  assign clk_rise = clk_lvl & ~clk_prev_r;

  ////////////////////////////////////////////////////////////////////////////////
  // array input vector and feedback
  logic [NUM_CELLS-1:0] q_r; // cell flip-flops
  logic [NUM_CELLS-1:0] fb; // feedback into array
  logic [NIN-1:0] arr_in;

  // feedback select mux per cell
  always_comb begin
    for (int c = 0; c < NUM_CELLS; c++) begin
      if (mode[c] == macrocell_pkg::CELL_REG) begin
        fb[c] = ~q_r[c];
      end else if (mode[c] == macrocell_pkg::CELL_INPUT) begin
        // neighbouring pin supplies the input
        fb[c] = (c < NUM_CELLS / 2) ? io_lvl[(c + 1) % NUM_CELLS]
                                    : io_lvl[(c + NUM_CELLS - 1) % NUM_CELLS];
      end else begin
        fb[c] = io_lvl[c];
      end
      // end cells: mux steered by inverted permit bit
      if ((c == 0 || c == NUM_CELLS - 1) && mode[c] == macrocell_pkg::CELL_COMB_OUT) begin
        fb[c] = ~register_permit_global_i; // no pin feedback here
      end
    end
  end

  // registered device masks clock and enable pins as data
  assign arr_in = {fb, oe_n_lvl & ~dev_registered, clk_lvl & ~dev_registered,
                   pin_r[NUM_DED_IN-1:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // and array: true and inverted literals
  logic [NUM_CELLS*NT-1:0] pterm;
  always_comb begin
    for (int p = 0; p < NUM_CELLS * NT; p++) begin
      pterm[p] = 1'h1; // no connection evaluates high
      for (int i = 0; i < NIN; i++) begin
        // both literals connected forces low
        if (fuse_true_i[p*NIN+i] && !arr_in[i]) begin
          pterm[p] = 1'h0;
        end
        if (fuse_comp_i[p*NIN+i] && arr_in[i]) begin
          pterm[p] = 1'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // or gates, polarity, enable and output muxes
  logic [NUM_CELLS-1:0] sum_t, xor_t, oe_term;
  always_comb begin
    for (int c = 0; c < NUM_CELLS; c++) begin
      oe_term[c] = pterm[c*NT + NT - 1];
      if (mode[c] == macrocell_pkg::CELL_COMB_IO_NR ||
          mode[c] == macrocell_pkg::CELL_COMB_IO_R) begin
        sum_t[c] = |pterm[c*NT +: NT-1]; // seven terms
      end else begin
        sum_t[c] = |pterm[c*NT +: NT]; // all eight terms
      end
      xor_t[c] = sum_t[c] ^ cell_polarity_local_i[c];
    end
  end

  // cell flip-flops, cleared at reset; config static
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      q_r <= {NUM_CELLS{macrocell_pkg::FF_RESET}};
    end else begin
      for (int c = 0; c < NUM_CELLS; c++) begin
        if (clk_rise && mode[c] == macrocell_pkg::CELL_REG) begin
          q_r[c] <= xor_t[c];
        end
      end
    end
  end

  // output pins: registered cell drives inverted q
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      io_pin_o <= '0;
      io_pin_oe_o <= '0;
    end else begin
      for (int c = 0; c < NUM_CELLS; c++) begin
        case (mode[c])
          macrocell_pkg::CELL_REG: begin
            io_pin_o[c] <= ~q_r[c];
            io_pin_oe_o[c] <= ~oe_n_lvl;
          end
          macrocell_pkg::CELL_COMB_OUT: begin
            io_pin_o[c] <= ~xor_t[c];
            io_pin_oe_o[c] <= 1'h1;
          end
          macrocell_pkg::CELL_COMB_IO_NR, macrocell_pkg::CELL_COMB_IO_R: begin
            io_pin_o[c] <= ~xor_t[c];
            io_pin_oe_o[c] <= oe_term[c];
          end
          default: begin
            io_pin_o[c] <= 1'h0;
            io_pin_oe_o[c] <= 1'h0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_reg_oe;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode[1] == macrocell_pkg::CELL_REG) |=> (io_pin_oe_o[1] == ~$past(oe_n_lvl));
  endproperty
  a_reg_oe: assert property (p_reg_oe) else $error("registered enable wrong");

  property p_input_off;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode[2] == macrocell_pkg::CELL_INPUT) |=> !io_pin_oe_o[2];
  endproperty
  a_input_off: assert property (p_input_off) else $error("input cell drives");

  property p_comb_on;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode[3] == macrocell_pkg::CELL_COMB_OUT) |=> io_pin_oe_o[3];
  endproperty
  a_comb_on: assert property (p_comb_on) else $error("comb output off");

  property p_capture;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_rise && mode[0] == macrocell_pkg::CELL_REG) |=> q_r[0] == $past(xor_t[0]);
  endproperty
  a_capture: assert property (p_capture) else $error("flip-flop missed edge");

  property p_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !clk_rise |=> $stable(q_r);
  endproperty
  a_hold: assert property (p_hold) else $error("flip-flop moved without edge");

  property p_fb;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode[4] == macrocell_pkg::CELL_REG) |-> fb[4] == ~q_r[4];
  endproperty
  a_fb: assert property (p_fb) else $error("registered feedback wrong");

  property p_mask;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    dev_registered |-> !arr_in[macrocell_pkg::CLK_PIN_POS] && !arr_in[macrocell_pkg::OE_PIN_POS];
  endproperty
  a_mask: assert property (p_mask) else $error("clock pin leaks into array");

  property p_empty;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (fuse_true_i[NIN-1:0] == '0 && fuse_comp_i[NIN-1:0] == '0) |-> pterm[0];
  endproperty
  a_empty: assert property (p_empty) else $error("empty term not high");

  property p_reset_low;
    @(posedge core_clk_i)
    !rst_n_i |=> q_r == '0;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("flip-flops not cleared");

  property p_both_low;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (|(fuse_true_i[NIN-1:0] & fuse_comp_i[NIN-1:0])) |-> !pterm[0];
  endproperty
  a_both_low: assert property (p_both_low) else $error("opposed literals not low");

  property p_io_enable;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode[5] == macrocell_pkg::CELL_COMB_IO_NR || mode[5] == macrocell_pkg::CELL_COMB_IO_R)
      |=> io_pin_oe_o[5] == $past(pterm[5*NT+NT-1]);
  endproperty
  a_io_enable: assert property (p_io_enable) else $error("io enable term wrong");

  property p_comb_drive;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode[6] == macrocell_pkg::CELL_COMB_OUT)
      |=> io_pin_o[6] == ~$past(|pterm[6*NT +: NT] ^ cell_polarity_local_i[6]);
  endproperty
  a_comb_drive: assert property (p_comb_drive) else $error("comb output value wrong");

  property p_neighbour;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode[2] == macrocell_pkg::CELL_INPUT) |-> fb[2] == io_lvl[3];
  endproperty
  a_neighbour: assert property (p_neighbour) else $error("input cell feedback wrong");

  property p_end_fb;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (mode[NUM_CELLS-1] == macrocell_pkg::CELL_COMB_OUT)
      |-> fb[NUM_CELLS-1] == ~register_permit_global_i;
  endproperty
  a_end_fb: assert property (p_end_fb) else $error("end cell feedback wrong");

  // registered path: edge seen, then the pin shows the inverted capture two edges on
  sequence s_edge_seen;
    clk_rise && mode[0] == macrocell_pkg::CELL_REG;
  endsequence

  sequence s_pin_follows;
    io_pin_o[0] == ~$past(xor_t[0], 2);
  endsequence

  property p_reg_path;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_edge_seen |=> ##1 s_pin_follows;
  endproperty
  a_reg_path: assert property (p_reg_path) else $error("registered pin wrong");
endmodule : programmable_macrocell_array

/* dv/board_model.sv */
`timescale 1ns/100ps
// board side of the cell pins: a strong board driver wherever the device lets go
module board_model (
  input wire logic [7:0] dev_drv_i, // device drive value
  input wire logic [7:0] dev_oe_i, // device drive enable
  input wire logic [7:0] board_val_i, // board drive value
  output logic [7:0] pin_o // resolved pin level
);
  // device wins where enabled, so a neighbour-input cell sees board data only where its neighbour is not driving
  assign pin_o = (dev_oe_i & dev_drv_i) | (~dev_oe_i & board_val_i);
endmodule : board_model

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
  localparam int unsigned NA = macrocell_pkg::NUM_ARRAY_IN; // array inputs per term
  logic core_clk_i = 1'h0, rst_n_i = 1'h0, clk_pin_i = 1'h0, oe_n_pin_i = 1'h1;
  logic permit = 1'h1, emul = 1'h0; // global config bits
  logic [11:0] data_pin_i = 12'h000;
  logic [7:0] io_pin_i, io_pin_o, io_pin_oe_o;
  logic [7:0] board_val = 8'h00, mode_l = 8'h00, pol_l = 8'h00, q_m = 8'h00;
  logic [8*8*NA-1:0] ft = '0, fc = '0; // fuse maps
  int kind [64]; // 0 empty, 1 true, 2 complement, 3 both
  int sel [64]; // array input used by each term: data, clock or enable pin
  int error_cnt = 0, num_checks = 0, cyc = 0;

  programmable_macrocell_array programmable_macrocell_array_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .data_pin_i(data_pin_i),
    .clk_pin_i(clk_pin_i), .oe_n_pin_i(oe_n_pin_i), .io_pin_i(io_pin_i),
    .io_pin_o(io_pin_o), .io_pin_oe_o(io_pin_oe_o),
    .register_permit_global_i(permit), .emulation_select_global_i(emul),
    .cell_mode_local_i(mode_l), .cell_polarity_local_i(pol_l),
    .fuse_true_i(ft), .fuse_comp_i(fc));
  board_model board_model_inst (.dev_drv_i(io_pin_o), .dev_oe_i(io_pin_oe_o),
    .board_val_i(board_val), .pin_o(io_pin_i));

  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic arr_val(int i);
    if (i < 12) return data_pin_i[i];
    if (permit == 1'h0) return 1'h0; // registered device: clock and enable read low
    return (i == 12) ? clk_pin_i : oe_n_pin_i;
  endfunction : arr_val
  function automatic logic term_val(int p);
    case (kind[p])
      0: return 1'h1; // nothing connected reads high
      1: return arr_val(sel[p]);
      2: return ~arr_val(sel[p]);
      default: return 1'h0; // true and complement together
    endcase
  endfunction : term_val
  function automatic logic sum_val(int c, int n);
    logic s;
    s = 1'h0;
    for (int t = 0; t < n; t++) s |= term_val(c * 8 + t);
    return s;
  endfunction : sum_val

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask : tick

  // new static config and fuses, applied only under reset
  task automatic restart(logic p, logic e, logic [7:0] m);
    permit = p;
    emul = e;
    mode_l = m;
    pol_l = 8'($urandom);
    q_m = 8'h00;
    ft = '0;
    fc = '0;
    for (int q = 0; q < 64; q++) begin
      kind[q] = $urandom % 4;
      sel[q] = $urandom % 14;
      if (kind[q] == 1 || kind[q] == 3) ft[q*NA+sel[q]] = 1'h1;
      if (kind[q] >= 2) fc[q*NA+sel[q]] = 1'h1;
    end
    rst_n_i = 1'h0;
    tick(5);
    chk(io_pin_oe_o, 8'h00);
    rst_n_i = 1'h1;
  endtask : restart

  // one clock-pin pulse, long enough to be counted
  task automatic pulse();
    tick(4);
    clk_pin_i = 1'h1;
    for (int c = 0; c < 8; c++) begin
      if (permit == 1'h0 && emul == 1'h1) q_m[c] = sum_val(c, 8) ^ pol_l[c];
    end
    tick(4);
    clk_pin_i = 1'h0;
    tick(8);
  endtask : pulse

  // expected pins per cell from its mode, driven value masked by enable
  task automatic check_all();
    logic [7:0] eo, ee;
    for (int c = 0; c < 8; c++) begin
      case ({permit, emul, mode_l[c]})
        3'b010: {ee[c], eo[c]} = {~oe_n_pin_i, ~q_m[c]};
        3'b100: {ee[c], eo[c]} = {1'h1, ~(sum_val(c, 8) ^ pol_l[c])};
        3'b011, 3'b111: {ee[c], eo[c]} = {term_val(c * 8 + 7), ~(sum_val(c, 7) ^ pol_l[c])};
        default: {ee[c], eo[c]} = 2'h0;
      endcase
    end
    chk(io_pin_oe_o, ee);
    chk(io_pin_o & ee, eo & ee);
  endtask : check_all

  task automatic tally_and_finish();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////
  // main sequence: four device kinds, random cell modes (shifted all-ones for the second kind) and pins
  initial begin
    logic [1:0] kinds [4];
    kinds = '{2'b10, 2'b11, 2'b01, 2'b00};
    void'($urandom(21));
    tick(1);
    for (int k = 0; k < 4; k++) begin
      for (int r = 0; r < 4; r++) begin
        restart(kinds[k][1], kinds[k][0], (k == 1) ? (8'hff << r) : 8'($urandom));
        oe_n_pin_i = 1'h0;
        tick(8);
        check_all();
        for (int i = 0; i < 8; i++) begin
          data_pin_i = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
          board_val = 8'($urandom);
          oe_n_pin_i = (i < 4) ? 1'h0 : 1'($urandom);
          tick(8);
          pulse();
          check_all();
        end
      end
    end
    tally_and_finish();
  end
endmodule : testbench
